// File: core/phase_mode_startup_sequencer.sv
// start-up sequencer and operating-mode selector for a two-phase regulator
//
// Function
// - a low load-level select requests single-phase operation, whatever the other selects say.
// - the alternate compensation switch is closed in single-phase and open in two-phase.
// - the six voltage-code inputs form one binary number, bit 0 least significant.
// - the regulator runs only while the enable input is high.
// - after power-on reset and enable, wait about 100 us, then ramp toward the boot level.
// - during start-up both phases run continuous, whatever the selects say.
// - power-good is released about 7 ms after the soft-start ramp begins.
// - after start-up the mode follows the current select inputs.
// - in single-phase the second phase runs during soft-start and stops afterwards.
// - the thermal alarm is pulled low while over-temperature is sensed.
// - power-good is open drain: pulled low or released only.
// - selects decode: load high gives two-phase, load low one-phase, a=1 b=0 gives diode mode.
// - select requests are filtered: 2 periods to idle a phase, 7 to enter diode mode.
// - in diode mode any voltage-code change returns at once to two-phase continuous.
// - entering single-phase waits until a voltage-code ramp has finished.
`timescale 1ns/1ps
module phase_mode_startup_sequencer #(
  parameter int unsigned START_DELAY_CYC = seq_pkg::START_DELAY_CYC,
  parameter int unsigned POWER_GOOD_OUT_DELAY_CYC = seq_pkg::POWER_GOOD_OUT_DELAY_CYC,
  parameter int unsigned SW_PERIOD_CYC   = seq_pkg::SW_PERIOD_CYC,
  parameter int unsigned RAMP_STEP_CYC   = 400
) (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       supply_ok_in,
  input  wire logic       regulator_enable_in,
  input  wire logic       load_level_select_in,
  input  wire logic       save_select_a_in,
  input  wire logic       save_select_b_in,
  input  wire logic [5:0] voltage_code_in,
  input  wire logic       thermistor_hot_in,
  output logic            power_good_out,
  output logic            power_good_oe_out,
  output logic            thermal_alarm_n_out,
  output logic            thermal_alarm_n_oe_out,
  output logic            alt_comp_close_out,
  output logic            phase1_en_out,
  output logic            phase2_en_out,
  output logic            diode_emul_out,
  output logic [1:0]      mode_out,
  output logic [5:0]      ref_code_out,
  output logic            soft_start_out,
  output logic            ramp_busy_out
);
  localparam int unsigned CW = 32;

  typedef struct packed {
    logic [1:0]             en_sync;
    logic [1:0]             sup_sync;
    logic [1:0]             hot_sync;
    seq_pkg::select_t       sel_m;
    seq_pkg::select_t       sel_s;
    logic [5:0]             vc_m;
    logic [5:0]             vc_s;
    logic [5:0]             vc_last;
    seq_pkg::seq_state_t    state;
    logic [CW-1:0]          timer;
    logic [CW-1:0]          pg_timer;
    logic [CW-1:0]          per_cnt;
    logic [CW-1:0]          ramp_cnt;
    logic [5:0]             ref_code;
    logic [5:0]             target;
    logic                   pg;
    logic                   hot;
    seq_pkg::phase_ctl_t    ctl;
  } seq_t;

  seq_t st_ff;
  seq_t nxt_st;

  logic                 sw_tick;
  logic                 idle_ok;
  logic                 dcm_ok;
  logic                 run_ok;
  logic                 ramping;
  seq_pkg::op_mode_t    want_mode;

  assign sw_tick = (st_ff.per_cnt == CW'(SW_PERIOD_CYC - 1));
  assign run_ok  = st_ff.en_sync[1] && st_ff.sup_sync[1];
  assign ramping = (st_ff.ref_code != st_ff.target);

  // idle-phase request: load level low (single phase) or diode-select pattern
  period_filter #(
    .PERIODS (seq_pkg::IDLE_FILT_PER)
  ) u_idle_filt (
    .sys_clk_in   (sys_clk_in),
    .reset_n_in   (reset_n_in),
    .tick_in      (sw_tick),
    .request_in   (!st_ff.sel_s.load_level ||
                   (st_ff.sel_s.save_a && !st_ff.sel_s.save_b)),
    .accepted_out (idle_ok)
  );

  period_filter #(
    .PERIODS (seq_pkg::DCM_FILT_PER)
  ) u_dcm_filt (
    .sys_clk_in   (sys_clk_in),
    .reset_n_in   (reset_n_in),
    .tick_in      (sw_tick),
    .request_in   (st_ff.sel_s.save_a && !st_ff.sel_s.save_b),
    .accepted_out (dcm_ok)
  );

  always_comb begin
    if (dcm_ok && idle_ok) begin
      want_mode = seq_pkg::MODE_1P_DCM;
    end else if (idle_ok) begin
      want_mode = seq_pkg::MODE_1P_CCM;
    end else begin
      want_mode = seq_pkg::MODE_2P_CCM;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.en_sync  = {st_ff.en_sync[0], regulator_enable_in};
    nxt_st.sup_sync = {st_ff.sup_sync[0], supply_ok_in};
    nxt_st.hot_sync = {st_ff.hot_sync[0], thermistor_hot_in};
    nxt_st.sel_m    = '{save_a: save_select_a_in, save_b: save_select_b_in,
                        load_level: load_level_select_in};
    nxt_st.sel_s    = st_ff.sel_m;
    nxt_st.vc_m     = voltage_code_in;
    nxt_st.vc_s     = st_ff.vc_m;
    nxt_st.hot      = st_ff.hot_sync[1];
    nxt_st.per_cnt  = sw_tick ? '0 : st_ff.per_cnt + CW'(1);

    // reference walks one code step per ramp interval toward its target
    if (ramping) begin
      if (st_ff.ramp_cnt >= CW'(RAMP_STEP_CYC - 1)) begin
        nxt_st.ramp_cnt = '0;
        nxt_st.ref_code = (st_ff.ref_code < st_ff.target) ?
                          st_ff.ref_code + 6'h01 : st_ff.ref_code - 6'h01;
      end else begin
        nxt_st.ramp_cnt = st_ff.ramp_cnt + CW'(1);
      end
    end else begin
      nxt_st.ramp_cnt = '0;
    end

    if (!run_ok) begin
      nxt_st.state    = seq_pkg::ST_IDLE;
      nxt_st.timer    = '0;
      nxt_st.pg_timer = '0;
      nxt_st.pg       = 1'b0;
      nxt_st.ctl      = '{phase1_en: 1'b0, phase2_en: 1'b0, diode_emul: 1'b0,
                          alt_comp_close: 1'b0, mode: seq_pkg::MODE_2P_CCM};
      nxt_st.ref_code = seq_pkg::VCODE_RESET;
      nxt_st.target   = seq_pkg::VCODE_RESET;
      nxt_st.ramp_cnt = '0;
    end else begin
      case (st_ff.state)
        seq_pkg::ST_IDLE: begin
          nxt_st.state = seq_pkg::ST_DELAY;
          nxt_st.timer = '0;
        end
        seq_pkg::ST_DELAY: begin
          if (st_ff.timer >= CW'(START_DELAY_CYC - 1)) begin
            nxt_st.state    = seq_pkg::ST_SOFT;
            nxt_st.timer    = '0;
            nxt_st.target   = seq_pkg::BOOT_CODE;
            nxt_st.ctl      = '{phase1_en: 1'b1, phase2_en: 1'b1, diode_emul: 1'b0,
                                alt_comp_close: 1'b0, mode: seq_pkg::MODE_2P_CCM};
          end else begin
            nxt_st.timer = st_ff.timer + CW'(1);
          end
        end
        seq_pkg::ST_SOFT: begin
          if (st_ff.pg_timer >= CW'(POWER_GOOD_OUT_DELAY_CYC - 1)) begin
            nxt_st.state   = seq_pkg::ST_RUN;
            nxt_st.pg      = 1'b1;
            nxt_st.target  = st_ff.vc_s;
            nxt_st.vc_last = st_ff.vc_s;
          end else begin
            nxt_st.pg_timer = st_ff.pg_timer + CW'(1);
          end
        end
        default: begin
          nxt_st.target  = st_ff.vc_s;
          nxt_st.vc_last = st_ff.vc_s;
          if (st_ff.ctl.mode == seq_pkg::MODE_1P_DCM && st_ff.vc_s != st_ff.vc_last) begin
            nxt_st.ctl.mode = seq_pkg::MODE_2P_CCM;
          end else if (want_mode == seq_pkg::MODE_2P_CCM) begin
            nxt_st.ctl.mode = seq_pkg::MODE_2P_CCM;
          end else if (!ramping && st_ff.vc_s == st_ff.vc_last) begin
            nxt_st.ctl.mode = want_mode;
          end
          nxt_st.ctl.phase1_en      = 1'b1;
          nxt_st.ctl.phase2_en      = (nxt_st.ctl.mode == seq_pkg::MODE_2P_CCM);
          nxt_st.ctl.diode_emul     = (nxt_st.ctl.mode == seq_pkg::MODE_1P_DCM);
          nxt_st.ctl.alt_comp_close = (nxt_st.ctl.mode != seq_pkg::MODE_2P_CCM);
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // open-drain pins: the level driven is always low, only the enable moves
  assign power_good_out         = 1'b0;
  assign power_good_oe_out      = !st_ff.pg;
  assign thermal_alarm_n_out    = 1'b0;
  assign thermal_alarm_n_oe_out = st_ff.hot;
  assign alt_comp_close_out     = st_ff.ctl.alt_comp_close;
  assign phase1_en_out          = st_ff.ctl.phase1_en;
  assign phase2_en_out          = st_ff.ctl.phase2_en;
  assign diode_emul_out         = st_ff.ctl.diode_emul;
  assign mode_out               = st_ff.ctl.mode;
  assign ref_code_out           = st_ff.ref_code;
  assign soft_start_out         = (st_ff.state == seq_pkg::ST_SOFT);
  assign ramp_busy_out          = ramping;
endmodule

// File: core/seq_pkg.sv
// package: constants, modes and carriers for the start-up and mode sequencer
package seq_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned START_DELAY_US   = 100;
  localparam int unsigned START_DELAY_CYC  = START_DELAY_US * CLK_MHZ;
  localparam int unsigned POWER_GOOD_OUT_DELAY_MS   = 7;
  localparam int unsigned POWER_GOOD_OUT_DELAY_CYC  = POWER_GOOD_OUT_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned SW_PERIOD_NS     = 3340;
  localparam int unsigned SW_PERIOD_CYC    = SW_PERIOD_NS / 10;
  localparam int unsigned IDLE_FILT_PER    = 2;
  localparam int unsigned DCM_FILT_PER     = 7;
  localparam logic [5:0]  VCODE_RESET      = 6'h00;
  localparam logic [5:0]  BOOT_CODE        = 6'h0c;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DELAY = 3'b001,
    ST_SOFT  = 3'b010,
    ST_RUN   = 3'b011
  } seq_state_t;

  typedef enum logic [1:0] {
    MODE_2P_CCM = 2'b00,
    MODE_1P_CCM = 2'b01,
    MODE_1P_DCM = 2'b10
  } op_mode_t;

  typedef struct packed {
    logic save_a;
    logic save_b;
    logic load_level;
  } select_t;

  typedef struct packed {
    logic     phase1_en;
    logic     phase2_en;
    logic     diode_emul;
    logic     alt_comp_close;
    op_mode_t mode;
  } phase_ctl_t;
endpackage

// File: core/period_filter.sv
// period-counting glitch filter for one select request
`timescale 1ns/1ps
module period_filter #(
  parameter int unsigned PERIODS = 2
) (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic tick_in,
  input  wire logic request_in,
  output logic      accepted_out
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       acc;
  } filt_state_t;

  filt_state_t st_ff;
  filt_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!request_in) begin
      nxt_st.cnt = 4'h0;
      nxt_st.acc = 1'b0;
    end else if (tick_in && !st_ff.acc) begin
      if (st_ff.cnt >= 4'(PERIODS - 1)) begin
        nxt_st.acc = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign accepted_out = st_ff.acc;
endmodule

// File: testbench/seq_properties.sv
// checker: timing and decode properties of the start-up sequencer
`timescale 1ns/1ps
module seq_properties #(
  parameter int unsigned POWER_GOOD_OUT_DELAY_CYC = seq_pkg::POWER_GOOD_OUT_DELAY_CYC
) (
  input wire logic       sys_clk_in,
  input wire logic       reset_n_in,
  input wire logic       supply_ok_in,
  input wire logic       regulator_enable_in,
  input wire logic [5:0] voltage_code_in,
  input wire logic       thermistor_hot_in,
  input wire logic       power_good_oe_out,
  input wire logic       thermal_alarm_n_oe_out,
  input wire logic       alt_comp_close_out,
  input wire logic       phase1_en_out,
  input wire logic       phase2_en_out,
  input wire logic [1:0] mode_out,
  input wire logic [5:0] ref_code_out,
  input wire logic       soft_start_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // cycles spent in soft-start, held through run, cleared while phases are off
  // wide enough for the full-length power-good delay
  logic [31:0] soft_cnt_ff;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) soft_cnt_ff <= 32'h0000_0000;
    else if (soft_start_out) soft_cnt_ff <= soft_cnt_ff + 32'h0000_0001;
    else if (!phase1_en_out) soft_cnt_ff <= 32'h0000_0000;
  end
  a_comp_switch: assert property (alt_comp_close_out == (mode_out != seq_pkg::MODE_2P_CCM))
    else $error("compensation switch disagrees with mode");
  a_phase2_idle: assert property (mode_out != seq_pkg::MODE_2P_CCM |-> !phase2_en_out)
    else $error("second phase runs in single-phase mode");
  a_soft_two_phase: assert property (soft_start_out |-> phase1_en_out && phase2_en_out)
    else $error("soft-start not in two-phase");
  a_soft_ramp_step: assert property (soft_start_out && $past(soft_start_out)
    && $changed(ref_code_out) |-> ref_code_out == $past(ref_code_out) + 6'h01)
    else $error("soft-start reference step wrong");
  a_pg_delay: assert property ($fell(power_good_oe_out) |-> soft_cnt_ff + 32'h0000_0001 >=
    POWER_GOOD_OUT_DELAY_CYC && soft_cnt_ff <= POWER_GOOD_OUT_DELAY_CYC + 1) else $error("power good early or late");
  a_run_loss: assert property (!(regulator_enable_in && supply_ok_in) [*3] |=>
    !phase1_en_out && !phase2_en_out && power_good_oe_out) else $error("not off after disable");
  a_thermal_alarm: assert property ($stable(thermistor_hot_in) [*5] |->
    thermal_alarm_n_oe_out == thermistor_hot_in) else $error("thermal alarm wrong");
  a_dcm_exit: assert property ($changed(voltage_code_in) && mode_out == seq_pkg::MODE_1P_DCM
    |-> ##[1:5] mode_out == seq_pkg::MODE_2P_CCM) else $error("no return from diode mode");
endmodule
bind phase_mode_startup_sequencer seq_properties #(.POWER_GOOD_OUT_DELAY_CYC(POWER_GOOD_OUT_DELAY_CYC)) props (
  .sys_clk_in, .reset_n_in, .supply_ok_in, .regulator_enable_in, .voltage_code_in,
  .thermistor_hot_in, .power_good_oe_out, .thermal_alarm_n_oe_out, .alt_comp_close_out,
  .phase1_en_out, .phase2_en_out, .mode_out, .ref_code_out, .soft_start_out);

// File: testbench/sys_ctrl_model.sv
// system controller side: enable drive and open-drain pull-ups
`timescale 1ns/1ps
module sys_ctrl_model (
  input  wire logic en_req_in,
  input  wire logic pg_oe_in,
  input  wire logic pg_drive_in,
  input  wire logic hot_oe_in,
  input  wire logic hot_drive_n_in,
  output logic      enable_out,
  output logic      pg_pin_out,
  output logic      hot_pin_n_out
);
  assign enable_out    = en_req_in;
  // pull-ups give the high level whenever the block releases a pin
  assign pg_pin_out    = pg_oe_in ? pg_drive_in : 1'b1;
  assign hot_pin_n_out = hot_oe_in ? hot_drive_n_in : 1'b1;
endmodule

// File: testbench/phase_mode_startup_sequencer_tb.sv
// self-checking bench for the start-up and mode sequencer
`timescale 1ns/1ps
module phase_mode_startup_sequencer_tb;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic supply_ok_in = 1'b1;
  logic en_req = 1'b0;
  logic thermistor_hot_in = 1'b0;
  logic [5:0] voltage_code_in = seq_pkg::BOOT_CODE;
  seq_pkg::select_t sel = 3'b000;
  logic regulator_enable_in, power_good_oe_out, thermal_alarm_n_oe_out, alt_comp_close_out;
  logic power_good_out, thermal_alarm_n_out, ramp_busy_out;
  logic phase1_en_out, phase2_en_out, diode_emul_out, soft_start_out, pg_pin, hot_pin_n;
  logic [1:0] mode_out;
  logic [5:0] ref_code_out;
  int errors = 0;
  int comparisons = 0;
  initial forever #5 sys_clk_in = ~sys_clk_in;
  phase_mode_startup_sequencer #(.START_DELAY_CYC(20), .POWER_GOOD_OUT_DELAY_CYC(200),
    .SW_PERIOD_CYC(4), .RAMP_STEP_CYC(2)) dut (.sys_clk_in, .reset_n_in, .supply_ok_in,
    .regulator_enable_in, .load_level_select_in(sel.load_level), .save_select_a_in(sel.save_a),
    .save_select_b_in(sel.save_b), .voltage_code_in, .thermistor_hot_in, .power_good_out,
    .power_good_oe_out, .thermal_alarm_n_out, .thermal_alarm_n_oe_out, .alt_comp_close_out,
    .phase1_en_out, .phase2_en_out, .diode_emul_out, .mode_out, .ref_code_out,
    .soft_start_out, .ramp_busy_out);
  sys_ctrl_model host (.en_req_in(en_req), .pg_oe_in(power_good_oe_out),
    .pg_drive_in(power_good_out), .hot_oe_in(thermal_alarm_n_oe_out),
    .hot_drive_n_in(thermal_alarm_n_out), .enable_out(regulator_enable_in),
    .pg_pin_out(pg_pin), .hot_pin_n_out(hot_pin_n));
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      #1;
    end
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chk_mode(input logic [1:0] m);
    chk("mode", 8'(mode_out), 8'(m));
    chk("phase2", 8'(phase2_en_out), 8'(m == seq_pkg::MODE_2P_CCM));
    chk("switch", 8'(alt_comp_close_out), 8'(m != seq_pkg::MODE_2P_CCM));
    chk("diode", 8'(diode_emul_out), 8'(m == seq_pkg::MODE_1P_DCM));
  endtask
  task automatic wait_pg(output int n);
    n = 0;
    while (pg_pin !== 1'b1 && n < 400) begin
      tk(1);
      n++;
    end
  endtask
  task automatic t_start;
    int n;
    int m;
    n = 0;
    m = 0;
    en_req <= 1'b1;
    while (soft_start_out !== 1'b1 && n < 100) begin
      tk(1);
      n++;
    end
    chk("start delay", 8'(n > 21 && n < 25), 8'h01);
    while (soft_start_out === 1'b1 && m < 400) begin
      chk_mode(seq_pkg::MODE_2P_CCM);
      tk(1);
      m++;
    end
    chk("boot", 8'(ref_code_out), 8'(seq_pkg::BOOT_CODE));
    chk("soft length", 8'(m > 198 && m < 202), 8'h01);
    tk(1);
    chk("pg", 8'(pg_pin), 8'h01);
    tk(40);
    chk_mode(seq_pkg::MODE_1P_CCM);
    $display("start-up done");
  endtask
  task automatic t_decode;
    logic [1:0] m;
    for (int i = 0; i < 8; i++) begin
      sel <= 3'(i);
      tk(80);
      m = i[2:1] == 2'b10 ? seq_pkg::MODE_1P_DCM : i[0] ? seq_pkg::MODE_2P_CCM : seq_pkg::MODE_1P_CCM;
      chk_mode(m);
    end
    $display("decode done");
  endtask
  task automatic t_filter;
    logic bad;
    bad = 1'b0;
    sel <= 3'b110;
    for (int k = 0; k < 60; k++) begin
      if (k == 3) sel <= 3'b111;
      if (k == 25) sel <= 3'b101;
      if (k == 45) sel <= 3'b111;
      tk(1);
      if (k < 25 && mode_out !== seq_pkg::MODE_2P_CCM) bad = 1'b1;
      if (mode_out === seq_pkg::MODE_1P_DCM) bad = 1'b1;
    end
    chk("glitch", 8'(bad), 8'h00);
    $display("filter done");
  endtask
  task automatic t_vcode;
    int n;
    logic bad;
    n = 0;
    bad = 1'b0;
    sel <= 3'b101;
    tk(80);
    chk_mode(seq_pkg::MODE_1P_DCM);
    voltage_code_in <= 6'h21;
    tk(6);
    chk_mode(seq_pkg::MODE_2P_CCM);
    chk("ramp busy", 8'(ramp_busy_out), 8'h01);
    while (ref_code_out !== 6'h21 && n < 200) begin
      if (mode_out !== seq_pkg::MODE_2P_CCM) bad = 1'b1;
      tk(1);
      n++;
    end
    chk("ramp hold", 8'(bad), 8'h00);
    chk("ref", 8'(ref_code_out), 8'h21);
    chk("ramp idle", 8'(ramp_busy_out), 8'h00);
    tk(80);
    chk_mode(seq_pkg::MODE_1P_DCM);
    $display("voltage code done");
  endtask
  task automatic t_loss;
    int n;
    thermistor_hot_in <= 1'b1;
    tk(5);
    chk("alarm", 8'(hot_pin_n), 8'h00);
    thermistor_hot_in <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      if (k == 0) en_req <= 1'b0;
      else supply_ok_in <= 1'b0;
      tk(5);
      chk("alarm off", 8'(hot_pin_n), 8'h01);
      chk("off", 8'({phase1_en_out, phase2_en_out, pg_pin}), 8'h00);
      en_req <= 1'b1;
      supply_ok_in <= 1'b1;
      wait_pg(n);
      chk("restart", 8'(n > 219 && n < 228), 8'h01);
    end
    $display("loss done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    tk(1);
    chk("reset", 8'({pg_pin, phase1_en_out, mode_out, 4'h0} | 8'(ref_code_out)), 8'h00);
    t_start;
    t_decode;
    t_filter;
    t_vcode;
    t_loss;
    stop_test;
  end
  initial begin
    repeat (6000) @(posedge sys_clk_in);
    errors++;
    stop_test;
  end
endmodule
